//--- fslp_pkg.sv
package fslp_pkg;
  // Avalon byte offsets of the controller's own registers
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STAT = 5'h0c;
  localparam logic [4:0] REG_RDATA = 5'h10;
  // Status register field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_ERR = 3;
  localparam int STAT_STS = 4;
  // Flash command codes, plus OTP lock, lock info and config code constants
  localparam logic [15:0] CMD_STS_CFG = 16'h00b8;
  localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] CMD_LOCK_SET = 16'h0001;
  localparam logic [15:0] CMD_LOCK_CLEAR = 16'h00d0;
  localparam logic [15:0] CMD_READ_ID = 16'h0090;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
  localparam logic [15:0] CMD_OTP_PROG = 16'h00c0;
  localparam logic [15:0] CMD_CLR_STAT = 16'h0050;
  localparam logic [15:0] OTP_LOCK_DATA = 16'hfffd;
  localparam logic [7:0] OTP_LOCK_WORD = 8'h80;
  localparam logic [7:0] LOCK_INFO_OFS = 8'h02;
  localparam logic [7:0] CFG_CODE_MASK = 8'h03;
  localparam logic [7:0] CFG_UNSUPPORTED = 8'h02;
  // Flash status register bits
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_PSUSP = 2;
  localparam int SR_LOCKED = 1;
  // Bus cycle phase lengths in clocks
  localparam logic [3:0] CYC_SETUP = 4'h2;
  localparam logic [3:0] CYC_STROBE = 4'h8;
  localparam logic [3:0] CYC_HOLD = 4'h3;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_STS_CFG = 4'h1, OP_SET_LOCK = 4'h2,
    OP_CLR_LOCKS = 4'h3, OP_PROG_OTP = 4'h4, OP_LOCK_OTP = 4'h5,
    OP_READ_LOCK = 4'h6, OP_READ_OTP = 4'h7, OP_CLR_STAT = 4'h8
  } fslp_op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CHK_W = 4'h1, S_CHK_R = 4'h2, S_SETUP = 4'h3,
    S_CONF = 4'h4, S_POLL = 4'h5, S_MODE = 4'h6, S_INFO = 4'h7,
    S_ARRAY = 4'h8, S_DONE = 4'h9
  } fslp_state_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0, E_SETUP = 2'h1, E_STROBE = 2'h2, E_HOLD = 2'h3
  } fslp_eng_t;
endpackage

//--- fslp_cyc_if.sv
`timescale 1ns/1ps
interface fslp_cyc_if #(parameter int AW = 24);
  logic req;
  logic wr;
  logic ack;
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport master (output req, wr, addr, wdata, input ack, rdata);
  modport engine (input req, wr, addr, wdata, output ack, rdata);
endinterface

//--- fslp_bus_cycle.sv
`timescale 1ns/1ps
module fslp_bus_cycle #(parameter int AW = 24) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request side
  fslp_cyc_if.engine cyc,
  // Flash pins
  output logic [AW-1:0] fl_addr_o,
  input wire logic [15:0] fl_dq_i,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_o,
  output logic fl_ce_n_o,
  output logic fl_we_n_o,
  output logic fl_oe_n_o
);
  fslp_pkg::fslp_eng_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [AW-1:0] next_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;
  logic wr, next_wr;
  logic [15:0] dq_meta, dq_sync;
  logic [3:0] we_low_cnt;

  // Strobe must outlast access time plus the two sync stages
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = fl_addr_o;
    next_wdata = wdata;
    next_wr = wr;
    next_rdata = rdata;
    unique case (state)
      fslp_pkg::E_IDLE: if (cyc.req) begin
        next_state = fslp_pkg::E_SETUP;
        next_cnt = fslp_pkg::CYC_SETUP - 4'h1;
        next_addr = cyc.addr;
        next_wdata = cyc.wdata;
        next_wr = cyc.wr;
      end
      fslp_pkg::E_SETUP: if (cnt == 4'h0) begin
        next_state = fslp_pkg::E_STROBE;
        next_cnt = fslp_pkg::CYC_STROBE - 4'h1;
      end else begin
        next_cnt = cnt - 4'h1;
      end
      fslp_pkg::E_STROBE: if (cnt == 4'h0) begin
        next_state = fslp_pkg::E_HOLD;
        next_cnt = fslp_pkg::CYC_HOLD - 4'h1;
        if (!wr) begin
          next_rdata = dq_sync;
        end
      end else begin
        next_cnt = cnt - 4'h1;
      end
      fslp_pkg::E_HOLD: if (cnt == 4'h0) begin
        next_state = fslp_pkg::E_IDLE;
      end else begin
        next_cnt = cnt - 4'h1;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= fslp_pkg::E_IDLE;
      cnt <= 4'h0;
      wdata <= 16'h0000;
      wr <= 1'b0;
      rdata <= 16'h0000;
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
      fl_addr_o <= '0;
      fl_dq_o <= 16'h0000;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      we_low_cnt <= 4'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wdata <= next_wdata;
      wr <= next_wr;
      rdata <= next_rdata;
      dq_meta <= fl_dq_i;
      dq_sync <= dq_meta;
      fl_addr_o <= next_addr;
      fl_dq_o <= next_wdata;
      // Data held through hold phase so it outlasts the write strobe
      fl_dq_oe_o <= (next_state != fslp_pkg::E_IDLE) && next_wr;
      fl_ce_n_o <= (next_state == fslp_pkg::E_IDLE);
      fl_we_n_o <= !((next_state == fslp_pkg::E_STROBE) && next_wr);
      fl_oe_n_o <= !((next_state == fslp_pkg::E_STROBE) && !next_wr);
      we_low_cnt <= fl_we_n_o ? 4'h0 : we_low_cnt + 4'h1;
    end
  end

  assign cyc.ack = (state == fslp_pkg::E_HOLD) && (cnt == 4'h0);
  assign cyc.rdata = rdata;

  a_we_low_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fl_we_n_o) |-> $past(we_low_cnt) == fslp_pkg::CYC_STROBE - 4'h1)
    else $error("write strobe width wrong");
  a_strobe_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    !(!fl_we_n_o && !fl_oe_n_o))
    else $error("write and read strobe together");
  a_dq_no_fight: assert property (@(posedge clk_i) disable iff (rst_i)
    fl_dq_oe_o |-> fl_oe_n_o && !fl_ce_n_o)
    else $error("data driven while flash may drive");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc.ack |=> !cyc.ack ##1 !cyc.ack)
    else $error("cycle ack not a lone pulse");
endmodule

//--- fslp_ctrl.sv
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// - Pin config: setup opcode, then code write
// - Configure only when ready, check status first
// - Both writes same die address
// - Set lock: setup, set code, block address
// - Clear locks: setup, clear code, any address
// - No lock ops while busy or suspended
// - Lock failures on error bits, host checks
// - Identifier mode reads it, read-array exits
// - Protection program: setup, then address/data
module fslp_ctrl #(
  parameter int AW = 24,
  parameter logic [15:0] READ_STATUS_CMD = 16'h0070
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Flash pins
  output logic [AW-1:0] FL_ADDR_O,
  input wire logic [15:0] FL_DQ_I,
  output logic [15:0] FL_DQ_O,
  output logic FL_DQ_OE_O,
  output logic FL_CE_N_O,
  output logic FL_WE_N_O,
  output logic FL_OE_N_O,
  output logic FL_RST_N_O,
  input wire logic FL_STS_I
);
  fslp_cyc_if #(.AW(AW)) cyc ();

  fslp_pkg::fslp_state_t state, next_state;
  fslp_pkg::fslp_op_t op, next_op;
  logic [AW-1:0] addr_q, next_addr, tgt_addr, otp_lock_addr;
  logic [15:0] wdata_q, next_wdata, rd_q, next_rd;
  logic [7:0] sr_q, next_sr, cfg_code;
  logic done, next_done, refused, next_refused, op_err, next_op_err;
  logic ack_q, next_ack, take_wr, start, clr_stat;
  logic set_done, set_refused, set_err;
  logic [31:0] next_avs_rdata;
  logic sts_meta, sts_sync;

  function automatic logic [31:0] apply_be(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic not_ready(input logic [15:0] sr);
    return !sr[fslp_pkg::SR_READY] || sr[fslp_pkg::SR_ESUSP] ||
      sr[fslp_pkg::SR_PSUSP];
  endfunction

  function automatic logic [15:0] setup_code(input fslp_pkg::fslp_op_t o);
    unique case (o)
      fslp_pkg::OP_STS_CFG: return fslp_pkg::CMD_STS_CFG;
      fslp_pkg::OP_SET_LOCK, fslp_pkg::OP_CLR_LOCKS:
        return fslp_pkg::CMD_LOCK_SETUP;
      fslp_pkg::OP_PROG_OTP, fslp_pkg::OP_LOCK_OTP:
        return fslp_pkg::CMD_OTP_PROG;
      default: return fslp_pkg::CMD_CLR_STAT;
    endcase
  endfunction

  function automatic logic op_failed(input fslp_pkg::fslp_op_t o,
      input logic [7:0] sr);
    unique case (o)
      fslp_pkg::OP_SET_LOCK: return sr[fslp_pkg::SR_PROG_ERR];
      fslp_pkg::OP_CLR_LOCKS: return sr[fslp_pkg::SR_ERASE_ERR];
      default: return sr[fslp_pkg::SR_PROG_ERR] || sr[fslp_pkg::SR_LOCKED];
    endcase
  endfunction

  // Reserved code bits always sent as zero
  assign cfg_code = wdata_q[7:0] & fslp_pkg::CFG_CODE_MASK;
  assign otp_lock_addr = {{(AW-8){1'b0}}, fslp_pkg::OTP_LOCK_WORD};
  // Same address for setup and confirm keeps the die select steady
  assign tgt_addr = (op == fslp_pkg::OP_LOCK_OTP) ? otp_lock_addr
                                                  : addr_q;

  // Avalon slave: one wait cycle, then registered answer
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_q;
  assign next_ack = (AVS_READ_I || AVS_WRITE_I) && !ack_q;
  assign take_wr = AVS_WRITE_I && ack_q;
  assign start = take_wr && (AVS_ADDRESS_I == fslp_pkg::REG_CTRL) &&
    AVS_BYTEENABLE_I[0];
  assign clr_stat = take_wr && (AVS_ADDRESS_I == fslp_pkg::REG_STAT) &&
    AVS_BYTEENABLE_I[0];

  always_comb begin
    next_avs_rdata = AVS_READDATA_O;
    if (AVS_READ_I && !ack_q) begin
      unique case (AVS_ADDRESS_I)
        fslp_pkg::REG_CTRL: next_avs_rdata = {28'h0000000, op};
        fslp_pkg::REG_ADDR: next_avs_rdata = 32'(addr_q);
        fslp_pkg::REG_WDATA: next_avs_rdata = {16'h0000, wdata_q};
        fslp_pkg::REG_STAT: next_avs_rdata = {16'h0000, sr_q, 3'h0,
          sts_sync, op_err, refused, done, state != fslp_pkg::S_IDLE};
        fslp_pkg::REG_RDATA: next_avs_rdata = {16'h0000, rd_q};
        default: next_avs_rdata = 32'h00000000;
      endcase
    end
  end

  // Flash cycle request per state
  always_comb begin
    cyc.req = 1'b1;
    cyc.wr = 1'b1;
    cyc.addr = tgt_addr;
    cyc.wdata = setup_code(op);
    unique case (state)
      fslp_pkg::S_IDLE, fslp_pkg::S_DONE: cyc.req = 1'b0;
      fslp_pkg::S_CHK_W: cyc.wdata = READ_STATUS_CMD;
      fslp_pkg::S_CHK_R, fslp_pkg::S_POLL: cyc.wr = 1'b0;
      fslp_pkg::S_SETUP: cyc.wdata = setup_code(op);
      fslp_pkg::S_CONF: begin
        unique case (op)
          fslp_pkg::OP_STS_CFG: cyc.wdata = {8'h00, cfg_code};
          fslp_pkg::OP_SET_LOCK: cyc.wdata = fslp_pkg::CMD_LOCK_SET;
          fslp_pkg::OP_CLR_LOCKS: cyc.wdata = fslp_pkg::CMD_LOCK_CLEAR;
          fslp_pkg::OP_LOCK_OTP: cyc.wdata = fslp_pkg::OTP_LOCK_DATA;
          default: cyc.wdata = wdata_q;
        endcase
      end
      fslp_pkg::S_MODE: cyc.wdata = fslp_pkg::CMD_READ_ID;
      fslp_pkg::S_INFO: begin
        cyc.wr = 1'b0;
        cyc.addr = (op == fslp_pkg::OP_READ_LOCK) ? AW'(addr_q +
          {{(AW-8){1'b0}}, fslp_pkg::LOCK_INFO_OFS}) : addr_q;
      end
      fslp_pkg::S_ARRAY: cyc.wdata = fslp_pkg::CMD_READ_ARRAY;
    endcase
  end

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr_q;
    next_wdata = wdata_q;
    next_rd = rd_q;
    next_sr = sr_q;
    set_done = 1'b0;
    set_refused = 1'b0;
    set_err = 1'b0;
    if (take_wr && AVS_ADDRESS_I == fslp_pkg::REG_ADDR) begin
      next_addr = AW'(apply_be(32'(addr_q), AVS_WRITEDATA_I,
        AVS_BYTEENABLE_I));
    end
    if (take_wr && AVS_ADDRESS_I == fslp_pkg::REG_WDATA) begin
      next_wdata = 16'(apply_be({16'h0000, wdata_q}, AVS_WRITEDATA_I,
        AVS_BYTEENABLE_I));
    end
    unique case (state)
      fslp_pkg::S_IDLE: if (start) begin
        next_op = fslp_pkg::fslp_op_t'(AVS_WRITEDATA_I[3:0]);
        unique case (AVS_WRITEDATA_I[3:0])
          fslp_pkg::OP_READ_LOCK, fslp_pkg::OP_READ_OTP:
            next_state = fslp_pkg::S_MODE;
          fslp_pkg::OP_CLR_STAT: next_state = fslp_pkg::S_SETUP;
          fslp_pkg::OP_STS_CFG:
            // Program-only pulse code is never sent
            if ((wdata_q[7:0] & fslp_pkg::CFG_CODE_MASK) ==
                fslp_pkg::CFG_UNSUPPORTED) begin
              next_state = fslp_pkg::S_DONE;
              set_refused = 1'b1;
            end else begin
              next_state = fslp_pkg::S_CHK_W;
            end
          fslp_pkg::OP_SET_LOCK, fslp_pkg::OP_CLR_LOCKS,
          fslp_pkg::OP_PROG_OTP, fslp_pkg::OP_LOCK_OTP:
            next_state = fslp_pkg::S_CHK_W;
          default: begin
            next_op = fslp_pkg::OP_NONE;
            set_refused = 1'b1;
          end
        endcase
      end
      fslp_pkg::S_CHK_W: if (cyc.ack) next_state = fslp_pkg::S_CHK_R;
      fslp_pkg::S_CHK_R: if (cyc.ack) begin
        next_sr = cyc.rdata[7:0];
        if (not_ready(cyc.rdata)) begin
          next_state = fslp_pkg::S_DONE;
          set_refused = 1'b1;
        end else begin
          next_state = fslp_pkg::S_SETUP;
        end
      end
      fslp_pkg::S_SETUP: if (cyc.ack) begin
        next_state = (op == fslp_pkg::OP_CLR_STAT) ? fslp_pkg::S_DONE
                                                   : fslp_pkg::S_CONF;
      end
      fslp_pkg::S_CONF: if (cyc.ack) begin
        next_state = (op == fslp_pkg::OP_STS_CFG) ? fslp_pkg::S_DONE
                                                  : fslp_pkg::S_POLL;
      end
      // Poll has no bound; a dead part keeps the controller busy
      fslp_pkg::S_POLL: if (cyc.ack && cyc.rdata[fslp_pkg::SR_READY]) begin
        next_sr = cyc.rdata[7:0];
        set_err = op_failed(op, cyc.rdata[7:0]);
        next_state = fslp_pkg::S_DONE;
      end
      fslp_pkg::S_MODE: if (cyc.ack) next_state = fslp_pkg::S_INFO;
      fslp_pkg::S_INFO: if (cyc.ack) begin
        next_rd = cyc.rdata;
        next_state = fslp_pkg::S_ARRAY;
      end
      fslp_pkg::S_ARRAY: if (cyc.ack) next_state = fslp_pkg::S_DONE;
      fslp_pkg::S_DONE: begin
        set_done = 1'b1;
        next_state = fslp_pkg::S_IDLE;
      end
    endcase
    // A start while busy is refused and leaves the running op alone
    if (start && state != fslp_pkg::S_IDLE) begin
      set_refused = 1'b1;
    end
    // Set wins over a clear in the same cycle
    next_done = set_done || (done && !(clr_stat &&
      AVS_WRITEDATA_I[fslp_pkg::STAT_DONE]));
    next_refused = set_refused || (refused && !(clr_stat &&
      AVS_WRITEDATA_I[fslp_pkg::STAT_REFUSED]));
    next_op_err = set_err || (op_err && !(clr_stat &&
      AVS_WRITEDATA_I[fslp_pkg::STAT_ERR]));
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= fslp_pkg::S_IDLE;
      op <= fslp_pkg::OP_NONE;
      addr_q <= '0;
      wdata_q <= 16'h0000;
      rd_q <= 16'h0000;
      sr_q <= 8'h00;
      done <= 1'b0;
      refused <= 1'b0;
      op_err <= 1'b0;
      ack_q <= 1'b0;
      AVS_READDATA_O <= 32'h00000000;
      // Idle level of the pin, so no false busy shows after reset
      sts_meta <= 1'b1;
      sts_sync <= 1'b1;
      FL_RST_N_O <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      addr_q <= next_addr;
      wdata_q <= next_wdata;
      rd_q <= next_rd;
      sr_q <= next_sr;
      done <= next_done;
      refused <= next_refused;
      op_err <= next_op_err;
      ack_q <= next_ack;
      AVS_READDATA_O <= next_avs_rdata;
      sts_meta <= FL_STS_I;
      sts_sync <= sts_meta;
      FL_RST_N_O <= 1'b1;
    end
  end

  fslp_bus_cycle #(.AW(AW)) u_cycle (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .cyc(cyc.engine),
    .fl_addr_o(FL_ADDR_O),
    .fl_dq_i(FL_DQ_I),
    .fl_dq_o(FL_DQ_O),
    .fl_dq_oe_o(FL_DQ_OE_O),
    .fl_ce_n_o(FL_CE_N_O),
    .fl_we_n_o(FL_WE_N_O),
    .fl_oe_n_o(FL_OE_N_O)
  );

  sequence s_setup_acked;
    state == fslp_pkg::S_SETUP && cyc.ack && op != fslp_pkg::OP_CLR_STAT;
  endsequence
  sequence s_confirm_same_addr;
    state == fslp_pkg::S_CONF && cyc.req && cyc.addr == $past(cyc.addr);
  endsequence

  a_bus_one_wait: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("avalon answer not after one wait");
  a_confirm_follows: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I) s_setup_acked |=> s_confirm_same_addr)
    else $error("confirm not at setup address");
  a_check_refuse: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I)
    state == fslp_pkg::S_CHK_R && cyc.ack && not_ready(cyc.rdata)
    |=> state == fslp_pkg::S_DONE ##1 refused && done)
    else $error("busy device not refused");
  a_lock_setup_code: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I) state == fslp_pkg::S_SETUP && cyc.req &&
    (op == fslp_pkg::OP_SET_LOCK || op == fslp_pkg::OP_CLR_LOCKS)
    |-> cyc.wr && cyc.wdata == fslp_pkg::CMD_LOCK_SETUP)
    else $error("lock setup opcode wrong");
  a_poll_ready: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I)
    state == fslp_pkg::S_POLL && cyc.ack && !cyc.rdata[fslp_pkg::SR_READY]
    |=> state == fslp_pkg::S_POLL && !cyc.wr)
    else $error("poll left before ready");
  a_info_exit: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I) state == fslp_pkg::S_INFO && cyc.ack
    |=> state == fslp_pkg::S_ARRAY && rd_q == $past(cyc.rdata))
    else $error("identifier mode not left");
  a_err_report: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I) state == fslp_pkg::S_POLL && cyc.ack &&
    cyc.rdata[fslp_pkg::SR_READY] && op == fslp_pkg::OP_CLR_LOCKS &&
    cyc.rdata[fslp_pkg::SR_ERASE_ERR] |=> op_err)
    else $error("unlock failure not reported");
endmodule

//--- fslp_flash_model.sv
`timescale 1ns/1ps
module fslp_flash_model (
  // Flash pins
  input wire logic rst_n_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_i,
  output logic [15:0] dq_o,
  output logic sts_o,
  // Fault controls
  input wire logic susp_i,
  input wire logic program_enable_voltage_input_ok_i
);
  logic [255:0] lock = '0;
  logic [15:0] otp [0:8];
  logic [1:0] cfg = 2'h0;
  logic [1:0] mode = 2'h0;
  logic [15:0] pend = '0;
  logic [5:0] err = '0;
  logic ready = 1'b1;
  logic [15:0] rd;
  logic [15:0] last = '0;
  logic [7:0] sr;
  wire [3:0] w = addr_i[3:0];
  wire otp_a = addr_i >= 24'h80 && addr_i <= 24'h88;
  initial begin
    foreach (otp[i]) otp[i] = 16'hffff;
    otp[0] = 16'hfffe;
  end
  assign sr = {ready, susp_i, err[5:4], 2'h0, err[1], 1'b0};
  always_comb begin
    rd = 16'h5a5a;
    if (mode == 2'h1) rd = {8'h0, sr};
    else if (mode == 2'h2 && addr_i[15:0] == 16'h2) begin
      rd = {15'h0, lock[addr_i[23:16]]};
    end else if (mode == 2'h2 && otp_a) rd = otp[w];
  end
  // Released bus shows inverted data so a stale value never matches
  assign dq_o = (!ce_n_i && !oe_n_i && !dq_oe_i) ? rd : ~last;
  always @(posedge oe_n_i) last <= rd;
  // No end-of-program or end-of-erase pulse is modelled, so pulse modes stay high
  assign sts_o = cfg == 2'h0 ? ready : 1'b1;
  always @(posedge we_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= 2'h0;
      mode <= 2'h0;
      pend <= '0;
    end else if (!ce_n_i) begin
      pend <= '0;
      if (pend == 16'h00b8) begin
        if (dq_i[1:0] == 2'h2) err[5:4] <= 2'h3;
        else cfg <= dq_i[1:0];
      end else if (pend == 16'h0060) begin
        ready <= 1'b0;
        ready <= #80 1'b1;
        if (!program_enable_voltage_input_ok_i) err[5:4] <= dq_i == 16'h1 ? 2'h1 : 2'h2;
        else if (dq_i == 16'h1) lock[addr_i[23:16]] <= 1'b1;
        else if (dq_i == 16'hd0) lock <= '0;
        else err[5:4] <= 2'h3;
      end else if (pend == 16'h00c0) begin
        ready <= 1'b0;
        ready <= #80 1'b1;
        if (!otp_a) err[4] <= 1'b1;
        else if (w == 4'h0) otp[0] <= otp[0] & dq_i;
        else if (w < 4'h5 || !otp[0][1]) {err[4], err[1]} <= 2'h3;
        else otp[w] <= otp[w] & dq_i;
      end else begin
        case (dq_i)
          16'h0070: mode <= 2'h1;
          16'h0050: err <= '0;
          16'h0090: mode <= 2'h2;
          16'h00ff: mode <= 2'h0;
          16'h0060, 16'h00c0: begin
            pend <= dq_i;
            mode <= 2'h1;
          end
          16'h00b8: pend <= dq_i;
          default: ;
        endcase
      end
    end
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic CLK_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic [4:0] av_addr = '0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = '0;
  logic [31:0] avs_rdata, q, st;
  logic avs_wait, fl_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_rst_n, fl_sts;
  logic [23:0] fl_addr;
  logic [15:0] fl_dqi, fl_dqo;
  logic susp = 1'b0;
  logic program_enable_voltage_input_ok = 1'b1;
  logic sts_low;
  logic [62:0] r;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  // op, addr, wdata, err, sts low seen, check rdata, rdata
  localparam logic [62:0] ROWS [16] = '{
    {4'h1, 24'h0, 16'hfd, 3'b000, 16'h0}, {4'h2, 24'h30000, 16'h0, 3'b000, 16'h0},
    {4'h1, 24'h0, 16'h03, 3'b000, 16'h0}, {4'h2, 24'h40000, 16'h0, 3'b000, 16'h0},
    {4'h6, 24'h30000, 16'h0, 3'b001, 16'h1}, {4'h6, 24'h60000, 16'h0, 3'b001, 16'h0},
    {4'h1, 24'h0, 16'h00, 3'b000, 16'h0}, {4'h3, 24'h0, 16'h0, 3'b010, 16'h0},
    {4'h6, 24'h40000, 16'h0, 3'b001, 16'h0}, {4'h4, 24'h85, 16'h1234, 3'b010, 16'h0},
    {4'h7, 24'h85, 16'h0, 3'b001, 16'h1234}, {4'h5, 24'h0, 16'h0, 3'b010, 16'h0},
    {4'h4, 24'h86, 16'h5555, 3'b110, 16'h0}, {4'h8, 24'h0, 16'h0, 3'b000, 16'h0},
    {4'h4, 24'h90, 16'h5555, 3'b110, 16'h0}, {4'h8, 24'h0, 16'h0, 3'b000, 16'h0}};
  always #2 CLK_I = ~CLK_I;
  fslp_ctrl u_dut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .AVS_ADDRESS_I(av_addr), .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr),
    .AVS_WRITEDATA_I(av_wdata), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(avs_wait),
    .FL_ADDR_O(fl_addr), .FL_DQ_I(fl_dqi), .FL_DQ_O(fl_dqo),
    .FL_DQ_OE_O(fl_oe), .FL_CE_N_O(fl_ce_n), .FL_WE_N_O(fl_we_n),
    .FL_OE_N_O(fl_oe_n), .FL_RST_N_O(fl_rst_n), .FL_STS_I(fl_sts));
  fslp_flash_model u_flash (.rst_n_i(fl_rst_n), .ce_n_i(fl_ce_n),
    .we_n_i(fl_we_n), .oe_n_i(fl_oe_n), .addr_i(fl_addr), .dq_i(fl_dqo),
    .dq_oe_i(fl_oe), .dq_o(fl_dqi), .sts_o(fl_sts), .susp_i(susp),
    .program_enable_voltage_input_ok_i(program_enable_voltage_input_ok));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      end_sim;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Waitrequest and read data taken at the edge that ends the transfer
  task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    av_addr <= a;
    av_wdata <= d;
    av_rd <= rd;
    av_wr <= !rd;
    do begin
      @(posedge CLK_I);
    end while (avs_wait !== 1'b0);
    q = avs_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic wait_done;
    sts_low = 1'b0;
    do begin
      av(1'b1, fslp_pkg::REG_STAT, '0);
      if (q[fslp_pkg::STAT_STS] === 1'b0) sts_low = 1'b1;
    end while (q[fslp_pkg::STAT_DONE] !== 1'b1);
    st = q;
    av(1'b0, fslp_pkg::REG_STAT, 32'he);
  endtask
  task automatic run_op(input logic [3:0] op, input logic [23:0] a,
      input logic [15:0] d);
    av(1'b0, fslp_pkg::REG_ADDR, {8'h0, a});
    av(1'b0, fslp_pkg::REG_WDATA, {16'h0, d});
    av(1'b0, fslp_pkg::REG_CTRL, {28'h0, op});
    wait_done;
  endtask
  task automatic rd_lock(input logic [23:0] a);
    run_op(4'h6, a, 16'h0);
    av(1'b1, fslp_pkg::REG_RDATA, '0);
  endtask
  initial begin
    repeat (5) @(posedge CLK_I);
    chk("rst_n", 32'h0, {31'h0, fl_rst_n});
    @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      run_op(r[62:59], r[58:35], r[34:19]);
      chk("stat", {16'h0, 1'b1, 11'h0, r[18], 3'b010}, st & 32'h800f);
      chk("sts_low", {31'h0, r[17]}, {31'h0, sts_low});
      if (r[16]) begin
        av(1'b1, fslp_pkg::REG_RDATA, '0);
        chk("rdata", {16'h0, r[15:0]}, q & 32'hffff);
      end
      $display("row %0d done", i);
    end
    av(1'b0, fslp_pkg::REG_ADDR, 32'h30000);
    av(1'b0, fslp_pkg::REG_CTRL, 32'h2);
    av(1'b0, fslp_pkg::REG_CTRL, 32'h2);
    wait_done;
    chk("busy_refuse", 32'h6, st & 32'he);
    susp <= 1'b1;
    run_op(4'h3, 24'h0, 16'h0);
    chk("susp_refuse", 32'h6, st & 32'he);
    susp <= 1'b0;
    rd_lock(24'h30000);
    chk("lock_kept", 32'h1, q & 32'h1);
    $display("refusal test done");
    program_enable_voltage_input_ok <= 1'b0;
    run_op(4'h3, 24'h0, 16'h0);
    chk("program_enable_voltage_input_err", 32'ha, st & 32'he);
    program_enable_voltage_input_ok <= 1'b1;
    rd_lock(24'h30000);
    chk("program_enable_voltage_input_lock", 32'h1, q & 32'h1);
    run_op(4'h8, 24'h0, 16'h0);
    run_op(4'h1, 24'h0, 16'h2);
    chk("cfg_refuse", 32'h6, st & 32'he);
    run_op(4'h1, 24'h0, 16'h3);
    $display("program_enable_voltage_input test done");
    SYS_RST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk("rst_n2", 32'h0, {31'h0, fl_rst_n});
    SYS_RST_I <= 1'b0;
    rd_lock(24'h30000);
    chk("lock_rst", 32'h1, q & 32'h1);
    run_op(4'h2, 24'h40000, 16'h0);
    chk("cfg_default", 32'h1, {31'h0, sts_low});
    av(1'b1, 5'h14, '0);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
    end_sim;
  end
endmodule
